// File: logic/gcs_pkg.sv
// Package for the gauge current-state block: map, fields, resets, modes
package gcs_pkg;
	// Register word indices; byte address is four times the index
	localparam logic [5:0] IDX_ZERO_BAND = 6'h00;
	localparam logic [5:0] IDX_DESIGN_CAP = 6'h01;
	localparam logic [5:0] IDX_LOAD_CFG = 6'h02;
	localparam logic [5:0] IDX_DSG_RATE = 6'h03;
	localparam logic [5:0] IDX_CHG_RATE = 6'h04;
	localparam logic [5:0] IDX_QUIT_RATE = 6'h05;
	localparam logic [5:0] IDX_DSG_RELAX = 6'h06;
	localparam logic [5:0] IDX_CHG_RELAX = 6'h07;
	localparam logic [5:0] IDX_QUIT_RELAX = 6'h08;
	localparam logic [5:0] IDX_TRANS_FACT = 6'h09;
	localparam logic [5:0] IDX_IR_LIMIT = 6'h0A;
	localparam logic [5:0] IDX_QMAX = 6'h0B;
	localparam logic [5:0] IDX_DESIGN_ENERGY = 6'h0C;
	localparam logic [5:0] IDX_STATUS = 6'h0D;
	localparam logic [5:0] IDX_FILT_CUR = 6'h0E;
	localparam logic [5:0] IDX_QMAX_MAH = 6'h0F;
	localparam logic [5:0] IDX_LOAD_RATE = 6'h10;
	localparam logic [5:0] IDX_R_ADJ = 6'h11;
	localparam logic [5:0] IDX_IR_CORR = 6'h12;
	// Reset values
	localparam logic [7:0] RST_ZERO_BAND = 8'h0F;
	localparam logic [15:0] RST_DESIGN_CAP = 16'h0979;
	localparam logic [7:0] RST_LOAD_CFG = 8'h00;
	localparam logic [15:0] RST_DSG_RATE = 16'h00A7;
	localparam logic [15:0] RST_CHG_RATE = 16'h0064;
	localparam logic [15:0] RST_QUIT_RATE = 16'h00FA;
	localparam logic [15:0] RST_DSG_RELAX = 16'h003C;
	localparam logic [7:0] RST_CHG_RELAX = 8'h3C;
	localparam logic [7:0] RST_QUIT_RELAX = 8'h01;
	localparam logic [7:0] RST_TRANS_FACT = 8'hB3;
	localparam logic [15:0] RST_IR_LIMIT = 16'h0190;
	localparam logic [15:0] RST_QMAX = 16'h4333;
	localparam logic [15:0] RST_DESIGN_ENERGY = 16'h1C6B;
	// Load configuration byte fields
	localparam int LDCFG_MODE_BIT = 7;
	localparam int LDCFG_SEL_LSB = 0;
	localparam int LDCFG_SEL_W = 3;
	// Load selector codes
	localparam logic [2:0] SEL_PREV = 3'h0;
	localparam logic [2:0] SEL_NOW = 3'h1;
	localparam logic [2:0] SEL_AVG = 3'h2;
	localparam logic [2:0] SEL_LPF = 3'h3;
	localparam logic [2:0] SEL_RATED5 = 3'h4;
	localparam logic [2:0] SEL_USER = 3'h6;
	// Arithmetic constants
	localparam logic [19:0] RATE_TENTHS = 20'h0000A;
	localparam logic [15:0] RATED_DIV = 16'h0005;
	localparam int QMAX_SHIFT = 14;
	localparam int TRANS_SHIFT = 8;
	// Operating mode codes as seen by software
	localparam logic [1:0] MODE_CHG = 2'h0;
	localparam logic [1:0] MODE_DSG = 2'h1;
	localparam logic [1:0] MODE_RLX = 2'h2;
	typedef enum logic [1:0] {GCS_CHG, GCS_DSG, GCS_RLX} gcs_mode_t;
endpackage

// File: logic/gcs_top.sv
// Gauge current filter, charge/discharge/relax machine and load model
//
// Functional notes
// - Filtered current zero below zero band
// - Three modes; discharge flag clear only charging
// - Discharge threshold is capacity*10 over divisor
// - Charge threshold is capacity*10 over divisor
// - Quit threshold is capacity*10 over divisor
// - Charge to relax after quit dwell
// - Enter discharge after discharge-entry dwell
// - Discharge to relax above negative quit
// - Enter charge above charge threshold dwell
// - Resistance scaled by transient factor over 256
// - IR correction capped, only after charging wakeup
// - Chemical capacity times rated, shift fourteen
// - Load model from config bit seven
// - Load model status mirrors config bit
// - Selector from config bits two to zero
// - Constant-current selector picks load source
// - Constant-power selector six is user rate
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps

module gcs_dwell #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic restart,
	input wire logic cond,
	input wire logic tick,
	input wire logic [W-1:0] limit,
	// Result
	output logic done
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic sat;

	// Saturating seconds count while the condition holds
	assign sat = &cnt_r;
	assign cnt_nxt = (restart | ~cond) ? '0 :
		((tick & ~sat) ? cnt_r + 1'b1 : cnt_r);
	// Restart is left out of done: it comes from the mode decision that
	// done feeds, and would close a combinational loop
	assign done = cond & (cnt_r >= limit);

	// Count register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end
endmodule

module gcs_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Measurement
	input wire logic signed [15:0] est_current,
	input wire logic sec_tick,
	// Load sources
	input wire logic signed [15:0] avg_prev_cycle,
	input wire logic signed [15:0] avg_this_cycle,
	input wire logic signed [15:0] avg_filtered,
	input wire logic signed [15:0] lpf_filtered,
	input wire logic signed [15:0] user_rate,
	// Resistance and IR correction
	input wire logic [15:0] r_calc,
	input wire logic [15:0] ir_drop,
	input wire logic wake_chg,
	// Results
	output logic signed [15:0] filtered_cell_current,
	output logic [1:0] op_mode,
	output logic dsg_flag,
	output logic load_model_status,
	output logic signed [15:0] load_rate,
	output logic load_sel_rsvd,
	output logic signed [17:0] qmax_mah,
	output logic [15:0] r_adj,
	output logic [15:0] ir_correction
);
	logic [7:0] zero_band_r;
	logic [15:0] cap_r;
	logic [7:0] load_cfg_r;
	logic [15:0] dsg_rate_r;
	logic [15:0] chg_rate_r;
	logic [15:0] quit_rate_r;
	logic [15:0] dsg_relax_r;
	logic [7:0] chg_relax_r;
	logic [7:0] quit_relax_r;
	logic [7:0] tf_chg_r;
	logic [7:0] tf_dsg_r;
	logic [15:0] ir_limit_r;
	logic signed [15:0] qmax_r;
	logic [15:0] energy_r;
	gcs_pkg::gcs_mode_t mode_r;
	gcs_pkg::gcs_mode_t mode_nxt;

	// Threshold in mA: capacity / (divisor * 0.1); zero divisor gives the maximum, 20'hFFFFF
	function automatic logic [19:0] rate_thr(input logic [15:0] cap,
		input logic [15:0] div);
		logic [19:0] num;
		num = 20'(cap) * gcs_pkg::RATE_TENTHS;
		if (div == 16'h0000)
			rate_thr = 20'hFFFFF;
		else
			rate_thr = num / 20'(div);
	endfunction

	// APB decode; zero wait states, so every access ends in one cycle
	logic [5:0] idx;
	logic setup;
	logic wr_en;
	logic mapped;
	logic read_only;
	assign idx = paddr[7:2];
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite & pready;
	assign mapped = (idx <= gcs_pkg::IDX_IR_CORR);
	assign read_only = (idx >= gcs_pkg::IDX_STATUS);

	// Current dead band
	logic [16:0] mag;
	logic in_band;
	logic signed [15:0] filt_nxt;
	assign mag = est_current[15] ? 17'h00000 - {1'b1, est_current}
		: {1'b0, est_current};
	assign in_band = mag < {9'h000, zero_band_r};
	assign filt_nxt = in_band ? 16'sh0000 : est_current;

	// Thresholds as 21-bit signed for comparison with the current
	logic [19:0] dsg_thr;
	logic [19:0] chg_thr;
	logic [19:0] quit_thr;
	logic signed [20:0] fe;
	assign dsg_thr = rate_thr(cap_r, dsg_rate_r);
	assign chg_thr = rate_thr(cap_r, chg_rate_r);
	assign quit_thr = rate_thr(cap_r, quit_rate_r);
	assign fe = {{5{filtered_cell_current[15]}}, filtered_cell_current};

	// Qualifying conditions; discharge current is negative
	logic c_quit_chg;
	logic c_dsg_in;
	logic c_dsg_out;
	logic c_chg_in;
	assign c_quit_chg = fe < $signed({1'b0, quit_thr});
	assign c_dsg_in = fe < -$signed({1'b0, dsg_thr});
	assign c_dsg_out = fe > -$signed({1'b0, quit_thr});
	assign c_chg_in = fe > $signed({1'b0, chg_thr});

	// Dwell timers restart on any mode change
	logic mode_move;
	logic t_chg_out;
	logic t_dsg_in;
	logic t_dsg_out;
	logic t_chg_in;
	assign mode_move = (mode_nxt != mode_r);

	gcs_dwell #(.W(16)) u_chg_out (
		.clk(pclk), .rst_n(presetn), .restart(mode_move),
		.cond(c_quit_chg), .tick(sec_tick),
		.limit({8'h00, chg_relax_r}), .done(t_chg_out)
	);
	gcs_dwell #(.W(16)) u_dsg_in (
		.clk(pclk), .rst_n(presetn), .restart(mode_move),
		.cond(c_dsg_in), .tick(sec_tick),
		.limit({8'h00, quit_relax_r}), .done(t_dsg_in)
	);
	gcs_dwell #(.W(16)) u_dsg_out (
		.clk(pclk), .rst_n(presetn), .restart(mode_move),
		.cond(c_dsg_out), .tick(sec_tick),
		.limit(dsg_relax_r), .done(t_dsg_out)
	);
	gcs_dwell #(.W(16)) u_chg_in (
		.clk(pclk), .rst_n(presetn), .restart(mode_move),
		.cond(c_chg_in), .tick(sec_tick),
		.limit({8'h00, chg_relax_r}), .done(t_chg_in)
	);

	// Mode transitions; discharge entry wins over relaxing from charge
	always_comb
	begin
		mode_nxt = mode_r;
		case (mode_r)
			gcs_pkg::GCS_CHG:
				if (t_dsg_in)
					mode_nxt = gcs_pkg::GCS_DSG;
				else if (t_chg_out)
					mode_nxt = gcs_pkg::GCS_RLX;
			gcs_pkg::GCS_DSG:
				if (t_chg_in)
					mode_nxt = gcs_pkg::GCS_CHG;
				else if (t_dsg_out)
					mode_nxt = gcs_pkg::GCS_RLX;
			gcs_pkg::GCS_RLX:
				if (t_dsg_in)
					mode_nxt = gcs_pkg::GCS_DSG;
				else if (t_chg_in)
					mode_nxt = gcs_pkg::GCS_CHG;
			default:
				mode_nxt = gcs_pkg::GCS_RLX;
		endcase
	end

	// Software-visible mode code
	logic [1:0] mode_code;
	assign mode_code = (mode_nxt == gcs_pkg::GCS_CHG) ? gcs_pkg::MODE_CHG :
		((mode_nxt == gcs_pkg::GCS_DSG) ? gcs_pkg::MODE_DSG :
		gcs_pkg::MODE_RLX);

	// Load model selection
	logic cp_mode;
	logic [2:0] sel;
	logic signed [15:0] rate_nxt;
	logic rsvd_nxt;
	logic [15:0] rated5;
	assign cp_mode = load_cfg_r[gcs_pkg::LDCFG_MODE_BIT];
	assign sel = load_cfg_r[gcs_pkg::LDCFG_SEL_LSB +:
		gcs_pkg::LDCFG_SEL_W];
	assign rated5 = (cp_mode ? energy_r : cap_r) / gcs_pkg::RATED_DIV;

	// Source per selector; reserved codes give zero and a flag
	always_comb
	begin
		rate_nxt = 16'sh0000;
		rsvd_nxt = 1'b0;
		case (sel)
			gcs_pkg::SEL_PREV: rate_nxt = avg_prev_cycle;
			gcs_pkg::SEL_NOW: rate_nxt = avg_this_cycle;
			gcs_pkg::SEL_AVG: rate_nxt = avg_filtered;
			gcs_pkg::SEL_LPF: rate_nxt = lpf_filtered;
			gcs_pkg::SEL_RATED5: rate_nxt = $signed(rated5);
			gcs_pkg::SEL_USER:
				if (cp_mode)
					rate_nxt = user_rate;
				else
					rsvd_nxt = 1'b1;
			default: rsvd_nxt = 1'b1;
		endcase
	end

	// Arithmetic results
	logic [7:0] tf;
	logic [23:0] r_prod;
	logic signed [32:0] q_prod;
	logic [15:0] ir_nxt;
	assign tf = (mode_r == gcs_pkg::GCS_CHG) ? tf_chg_r : tf_dsg_r;
	assign r_prod = 24'(r_calc) * 24'(tf);
	assign q_prod = qmax_r * $signed({1'b0, cap_r});
	assign ir_nxt = !wake_chg ? 16'h0000 :
		((ir_drop > ir_limit_r) ? ir_limit_r : ir_drop);

	// Read mux
	logic [31:0] rd_word;
	always_comb
	begin
		rd_word = 32'h00000000;
		case (idx)
			gcs_pkg::IDX_ZERO_BAND: rd_word = {24'h0, zero_band_r};
			gcs_pkg::IDX_DESIGN_CAP: rd_word = {16'h0, cap_r};
			gcs_pkg::IDX_LOAD_CFG: rd_word = {24'h0, load_cfg_r};
			gcs_pkg::IDX_DSG_RATE: rd_word = {16'h0, dsg_rate_r};
			gcs_pkg::IDX_CHG_RATE: rd_word = {16'h0, chg_rate_r};
			gcs_pkg::IDX_QUIT_RATE: rd_word = {16'h0, quit_rate_r};
			gcs_pkg::IDX_DSG_RELAX: rd_word = {16'h0, dsg_relax_r};
			gcs_pkg::IDX_CHG_RELAX: rd_word = {24'h0, chg_relax_r};
			gcs_pkg::IDX_QUIT_RELAX: rd_word = {24'h0, quit_relax_r};
			gcs_pkg::IDX_TRANS_FACT: rd_word = {16'h0, tf_dsg_r, tf_chg_r};
			gcs_pkg::IDX_IR_LIMIT: rd_word = {16'h0, ir_limit_r};
			gcs_pkg::IDX_QMAX: rd_word = {16'h0, qmax_r};
			gcs_pkg::IDX_DESIGN_ENERGY: rd_word = {16'h0, energy_r};
			gcs_pkg::IDX_STATUS: rd_word = {27'h0, load_sel_rsvd,
				load_model_status, dsg_flag, op_mode};
			gcs_pkg::IDX_FILT_CUR: rd_word = {16'h0, filtered_cell_current};
			gcs_pkg::IDX_QMAX_MAH: rd_word = {14'h0, qmax_mah};
			gcs_pkg::IDX_LOAD_RATE: rd_word = {16'h0, load_rate};
			gcs_pkg::IDX_R_ADJ: rd_word = {16'h0, r_adj};
			gcs_pkg::IDX_IR_CORR: rd_word = {16'h0, ir_correction};
			default: rd_word = 32'h00000000;
		endcase
	end

	// APB answer; data and error are latched in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= 1'b1;
			if (setup)
			begin
				prdata <= pwrite ? 32'h00000000 : rd_word;
				pslverr <= ~mapped | (pwrite & read_only);
			end
		end
	end

	// Parameter registers; reserved config bits are stored as written
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			zero_band_r <= gcs_pkg::RST_ZERO_BAND;
			cap_r <= gcs_pkg::RST_DESIGN_CAP;
			load_cfg_r <= gcs_pkg::RST_LOAD_CFG;
			dsg_rate_r <= gcs_pkg::RST_DSG_RATE;
			chg_rate_r <= gcs_pkg::RST_CHG_RATE;
			quit_rate_r <= gcs_pkg::RST_QUIT_RATE;
			dsg_relax_r <= gcs_pkg::RST_DSG_RELAX;
			chg_relax_r <= gcs_pkg::RST_CHG_RELAX;
			quit_relax_r <= gcs_pkg::RST_QUIT_RELAX;
			tf_chg_r <= gcs_pkg::RST_TRANS_FACT;
			tf_dsg_r <= gcs_pkg::RST_TRANS_FACT;
			ir_limit_r <= gcs_pkg::RST_IR_LIMIT;
			qmax_r <= gcs_pkg::RST_QMAX;
			energy_r <= gcs_pkg::RST_DESIGN_ENERGY;
		end
		else if (wr_en)
		begin
			case (idx)
				gcs_pkg::IDX_ZERO_BAND: zero_band_r <= pwdata[7:0];
				gcs_pkg::IDX_DESIGN_CAP: cap_r <= pwdata[15:0];
				gcs_pkg::IDX_LOAD_CFG: load_cfg_r <= pwdata[7:0];
				gcs_pkg::IDX_DSG_RATE: dsg_rate_r <= pwdata[15:0];
				gcs_pkg::IDX_CHG_RATE: chg_rate_r <= pwdata[15:0];
				gcs_pkg::IDX_QUIT_RATE: quit_rate_r <= pwdata[15:0];
				gcs_pkg::IDX_DSG_RELAX: dsg_relax_r <= pwdata[15:0];
				gcs_pkg::IDX_CHG_RELAX: chg_relax_r <= pwdata[7:0];
				gcs_pkg::IDX_QUIT_RELAX: quit_relax_r <= pwdata[7:0];
				gcs_pkg::IDX_TRANS_FACT:
				begin
					tf_chg_r <= pwdata[7:0];
					tf_dsg_r <= pwdata[15:8];
				end
				gcs_pkg::IDX_IR_LIMIT: ir_limit_r <= pwdata[15:0];
				gcs_pkg::IDX_QMAX: qmax_r <= pwdata[15:0];
				gcs_pkg::IDX_DESIGN_ENERGY: energy_r <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// Mode state and result registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_r <= gcs_pkg::GCS_RLX;
			op_mode <= gcs_pkg::MODE_RLX;
			dsg_flag <= 1'b1;
			filtered_cell_current <= 16'sh0000;
			load_model_status <= 1'b0;
			load_rate <= 16'sh0000;
			load_sel_rsvd <= 1'b0;
			qmax_mah <= 18'sh00000;
			r_adj <= 16'h0000;
			ir_correction <= 16'h0000;
		end
		else
		begin
			mode_r <= mode_nxt;
			op_mode <= mode_code;
			dsg_flag <= (mode_nxt != gcs_pkg::GCS_CHG);
			filtered_cell_current <= filt_nxt;
			load_model_status <= cp_mode;
			load_rate <= rate_nxt;
			load_sel_rsvd <= rsvd_nxt;
			qmax_mah <= q_prod[31:gcs_pkg::QMAX_SHIFT];
			r_adj <= r_prod[23:gcs_pkg::TRANS_SHIFT];
			ir_correction <= ir_nxt;
		end
	end
endmodule

// File: dv/gcs_top_chk.sv
// Port checker for the gauge current-state block, bound to its top
`timescale 1ns/1ps
module gcs_top_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	// Block signals
	input wire logic signed [15:0] est_current,
	input wire logic wake_chg,
	input wire logic [15:0] r_calc,
	input wire logic signed [15:0] filtered_cell_current,
	input wire logic [1:0] op_mode,
	input wire logic dsg_flag,
	input wire logic load_model_status,
	input wire logic [15:0] r_adj,
	input wire logic [15:0] ir_correction
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] band_r;
	logic mdl_r;
	// Shadow copies commit on the same edge as the block's registers
	wire wr_go = psel && penable && pwrite && pready;
	wire signed [16:0] band_s = {9'h000, band_r};
	wire in_band = (est_current < band_s) && (est_current > -band_s);
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			band_r <= gcs_pkg::RST_ZERO_BAND;
			mdl_r <= 1'b0;
		end
		else if (wr_go && paddr[7:2] == gcs_pkg::IDX_ZERO_BAND)
			band_r <= pwdata[7:0];
		else if (wr_go && paddr[7:2] == gcs_pkg::IDX_LOAD_CFG)
			mdl_r <= pwdata[gcs_pkg::LDCFG_MODE_BIT];
	// $past(presetn) skips the first edge, whose history is from reset
	property p_band_zero;
		$past(presetn) && $past(in_band) |-> filtered_cell_current == 0;
	endproperty
	a_band_zero: assert property (p_band_zero)
		else $error("current in band not zeroed");
	property p_band_pass;
		$past(presetn) && !$past(in_band)
			|-> filtered_cell_current == $past(est_current);
	endproperty
	a_band_pass: assert property (p_band_pass)
		else $error("current outside band not passed");
	property p_dsg_flag;
		dsg_flag == (op_mode != gcs_pkg::MODE_CHG);
	endproperty
	a_dsg_flag: assert property (p_dsg_flag)
		else $error("discharge flag wrong for mode");
	property p_enter_dsg;
		$past(presetn) && $changed(op_mode) && op_mode == gcs_pkg::MODE_DSG
			|-> $past(filtered_cell_current) < 0;
	endproperty
	a_enter_dsg: assert property (p_enter_dsg)
		else $error("discharge entered without discharge current");
	property p_enter_chg;
		$past(presetn) && $changed(op_mode) && op_mode == gcs_pkg::MODE_CHG
			|-> $past(filtered_cell_current) > 0;
	endproperty
	a_enter_chg: assert property (p_enter_chg)
		else $error("charge entered without charge current");
	property p_ir_off;
		$past(presetn) && !$past(wake_chg) |-> ir_correction == 16'h0000;
	endproperty
	a_ir_off: assert property (p_ir_off)
		else $error("IR correction without charging wakeup");
	property p_radj;
		$past(presetn) |-> r_adj <= $past(r_calc);
	endproperty
	a_radj: assert property (p_radj)
		else $error("scaled resistance above input");
	property p_load_model_status;
		$past(presetn) |-> load_model_status == $past(mdl_r);
	endproperty
	a_load_model_status: assert property (p_load_model_status)
		else $error("load model status does not follow config");
endmodule
bind gcs_top gcs_top_chk u_gcs_top_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .pready, .paddr, .pwdata, .est_current, .wake_chg, .r_calc,
	.filtered_cell_current, .op_mode, .dsg_flag, .load_model_status,
	.r_adj, .ir_correction);

// File: dv/gcs_host_model.sv
// APB host model that configures and reads the gauge block
`timescale 1ns/1ps
module gcs_host_model (
	// Clock
	input wire logic pclk,
	// APB master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// Idle bus at time zero
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// One transfer; released write data shows its inverse, not stale data
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e,
		output logic to);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= (a == 8'h08) ? (d & 32'hFFFFFF87) : d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 40);
		to = (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~pwdata;
	endtask
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the gauge current-state block
`timescale 1ns/1ps
module tb_top;
	logic pclk;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, sec_tick = 1'b0;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic signed [15:0] est_current = 16'sh0000;
	logic signed [15:0] filtered_cell_current, load_rate;
	logic [15:0] r_calc = 16'h03E8;
	logic [15:0] ir_drop = 16'h0000;
	logic [15:0] r_adj, ir_correction;
	logic wake_chg = 1'b0;
	logic [1:0] op_mode;
	logic dsg_flag, load_model_status, load_sel_rsvd;
	logic signed [17:0] qmax_mah;
	int err_total = 0;
	int n_compared = 0;
	gcs_host_model u_gcs_host_model (.pclk(pclk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	// Load sources hold distinct codes so each selection is visible
	gcs_top u_gcs_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.est_current(est_current), .sec_tick(sec_tick),
		.avg_prev_cycle(16'sh0101), .avg_this_cycle(16'sh0202),
		.avg_filtered(16'sh0303), .lpf_filtered(16'sh0404),
		.user_rate(16'sh0606), .r_calc(r_calc), .ir_drop(ir_drop),
		.wake_chg(wake_chg), .filtered_cell_current(filtered_cell_current),
		.op_mode(op_mode), .dsg_flag(dsg_flag),
		.load_model_status(load_model_status), .load_rate(load_rate),
		.load_sel_rsvd(load_sel_rsvd), .qmax_mah(qmax_mah), .r_adj(r_adj),
		.ir_correction(ir_correction));
	// Clock, 20 ns period
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic tally_and_finish;
		if (err_total == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		n_compared++;
		if (g !== x)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, x, g);
		end
	endtask
	// Bus wrappers; a hung transfer ends the run
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		logic to;
		u_gcs_host_model.xfer(w, a, d, q, e, to);
		if (to)
		begin
			err_total++;
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		bus(1'b1, a, d, q, e);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] q;
		logic e;
		bus(1'b0, a, 32'h0, q, e);
		chk("read data", x, q);
		chk("read error", {31'h0, xe}, {31'h0, e});
	endtask
	// Tick spacing leaves the compare cycle room before the next tick
	task automatic tick(input int n);
		repeat (n)
		begin
			sec_tick <= 1'b1;
			@(posedge pclk);
			sec_tick <= 1'b0;
			repeat (3) @(posedge pclk);
		end
	endtask
	task automatic cur(input logic signed [15:0] v);
		est_current <= v;
		repeat (3) @(posedge pclk);
	endtask
	task automatic md(input logic [1:0] m);
		chk("mode", {30'h0, m}, {30'h0, op_mode});
	endtask
	task automatic s_regs;
		logic [31:0] q;
		logic e;
		rdchk(8'h08, 32'h0, 1'b0);
		rdchk(8'h00, 32'h0F, 1'b0);
		rdchk(8'h3C, 32'h9F2, 1'b0);
		chk("qmax_mah", 32'h9F2, {14'h0, qmax_mah});
		chk("r_adj", 32'h2BB, {16'h0, r_adj});
		rdchk(8'h4C, 32'h0, 1'b1);
		bus(1'b1, 8'h34, 32'h3, q, e);
		chk("ro write", 32'h1, {31'h0, e});
		// Short charge and discharge dwell limits keep the run brief, then the transient factors
		wr(8'h1C, 32'h2);
		wr(8'h18, 32'h2);
		wr(8'h24, 32'h4080);
	endtask
	task automatic s_band;
		cur(16'sd14);
		chk("filt", 32'h0, filtered_cell_current);
		cur(-16'sd14);
		chk("filt", 32'h0, filtered_cell_current);
		cur(-16'sd15);
		chk("filt", -32'sd15, filtered_cell_current);
	endtask
	task automatic s_dsg;
		cur(-16'sd145);
		tick(3);
		md(gcs_pkg::MODE_RLX);
		cur(-16'sd146);
		md(gcs_pkg::MODE_RLX);
		tick(1);
		md(gcs_pkg::MODE_DSG);
		chk("r_adj", 32'hFA, {16'h0, r_adj});
		cur(-16'sd96);
		tick(1);
		cur(-16'sd97);
		cur(-16'sd96);
		tick(1);
		md(gcs_pkg::MODE_DSG);
		tick(1);
		md(gcs_pkg::MODE_RLX);
		chk("dsg_flag", 32'h1, {31'h0, dsg_flag});
	endtask
	task automatic s_chg;
		cur(16'sd242);
		tick(3);
		md(gcs_pkg::MODE_RLX);
		cur(16'sd243);
		tick(1);
		md(gcs_pkg::MODE_RLX);
		tick(1);
		md(gcs_pkg::MODE_CHG);
		chk("dsg_flag", 32'h0, {31'h0, dsg_flag});
		chk("r_adj", 32'h1F4, {16'h0, r_adj});
		cur(16'sd97);
		tick(2);
		md(gcs_pkg::MODE_CHG);
		cur(16'sd96);
		tick(2);
		md(gcs_pkg::MODE_RLX);
	endtask
	task automatic s_ir;
		wake_chg <= 1'b1;
		ir_drop <= 16'd500;
		repeat (2) @(posedge pclk);
		chk("ir", 32'h190, {16'h0, ir_correction});
		ir_drop <= 16'd300;
		repeat (2) @(posedge pclk);
		chk("ir", 32'd300, {16'h0, ir_correction});
		wake_chg <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("ir", 32'h0, {16'h0, ir_correction});
	endtask
	function automatic logic [15:0] rate_of(input logic m, input logic [2:0] s);
		case (s)
			gcs_pkg::SEL_PREV: return 16'h0101;
			gcs_pkg::SEL_NOW: return 16'h0202;
			gcs_pkg::SEL_AVG: return 16'h0303;
			gcs_pkg::SEL_LPF: return 16'h0404;
			gcs_pkg::SEL_RATED5: return m ? 16'h05AF : 16'h01E5;
			gcs_pkg::SEL_USER: return m ? 16'h0606 : 16'h0000;
			default: return 16'h0000;
		endcase
	endfunction
	// Every model and selector, reserved bits offered as ones but cleared by the host model
	task automatic s_load;
		logic m;
		logic [2:0] s;
		for (int i = 0; i < 16; i++)
		begin
			m = i[3];
			s = i[2:0];
			wr(8'h08, {24'h0, m, 4'hF, s});
			repeat (2) @(posedge pclk);
			chk("rate", {16'h0, rate_of(m, s)}, {16'h0, load_rate});
			chk("rsvd", {31'h0, s == 3'h5 || s == 3'h7 || (s == 3'h6 && !m)},
				{31'h0, load_sel_rsvd});
			chk("load_model_status", {31'h0, m}, {31'h0, load_model_status});
		end
		rdchk(8'h08, 32'h87, 1'b0);
	endtask
	// Reset for three cycles, then the scenarios
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		s_regs();
		s_band();
		s_dsg();
		s_chg();
		s_ir();
		s_load();
		tally_and_finish();
	end
endmodule
